/* File: logic/adcc_converter_control.v */
// Converter control, clock divider, channel routing and register slave
// Function
// - Result split: high byte 11..4, low nibble 3..0
// - Unimplemented register bits read back as zero
// - Conversion starts after start bit rises then falls
// - Start held high resets converter, busy set
// - Busy flag high during conversion, resets high
// - Channel select routes one of five inputs
// - Pin enable bit makes pin analog input
// - All enables zero: digital pins, converter off
// - Power bit active low, resets to off
// - Clock select picks system clock divide ratio
// - Conversion end sets interrupt request flag
// - Converter on when enables nonzero and power bit zero
//
// The Avalon-MM register port and the register addresses were left to the implementer.
`timescale 1ns/1ns
`include "adcc_defines.vh"
module adcc_converter_control (
    input  wire        clock,
    input  wire        rstn,
    input  wire        clockEn,
    input  wire [3:0]  address,
    input  wire        read,
    input  wire        write,
    input  wire [31:0] writedata,
    output reg  [31:0] readdata,
    output wire        waitrequest,
    output wire        irq,
    output wire [4:0]  analogPinEnables,
    output wire [2:0]  analogInputSel,
    output wire        converterOn,
    output wire        converterReset,
    output wire        converterStart,
    output wire        converterClockEn,
    input  wire        converterDone,
    input  wire [11:0] converterResult
);
    // ****************************************************************
    // Registers
    // ****************************************************************
    reg        startBit_reg;
    reg [2:0]  channelSelect_reg;
    reg        testBit_reg;
    reg        converterPowerOff_reg;
    reg [2:0]  clockSelect_reg;
    reg [4:0]  pinEnables_reg;
    reg        busy_reg;
    reg        irqStatus_reg;
    reg        irqMask_reg;
    reg        readPending_reg;
    reg [3:0]  readAddr_reg;
    reg        doneMeta_reg;
    reg        doneSync_reg;
    reg        doneSeen_reg;
    reg [4:0]  divCount_reg;
    reg [4:0]  divCount_next;
    reg [4:0]  divLimit;
    reg [2:0]  inputSel;
    wire [11:0] resultWord;
    wire        doneRise;
    wire        startFall;
    wire        conversionEnd;
    wire        writeConvCtrl;
    wire        readStatus;

    // ****************************************************************
    // Bus slave: writes take one cycle, reads answer one cycle later
    // ****************************************************************
    assign waitrequest   = read & ~readPending_reg;
    assign writeConvCtrl = write && (address == `ADCC_OFF_CONV_CTRL);
    assign startFall     = writeConvCtrl & startBit_reg & ~writedata[`ADCC_BIT_START];
    assign readStatus    = readPending_reg && (readAddr_reg == `ADCC_OFF_IRQ_STATUS);

    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            startBit_reg          <= 1'b0;
            channelSelect_reg     <= `ADCC_RST_CHSEL;
            testBit_reg           <= 1'b1;
            converterPowerOff_reg <= 1'b1;
            clockSelect_reg       <= `ADCC_RST_CLKSEL;
            pinEnables_reg        <= `ADCC_RST_PIN_CFG;
            irqMask_reg           <= 1'b0;
            readPending_reg       <= 1'b0;
            readAddr_reg          <= 4'h0;
        end else if (clockEn) begin
            readPending_reg <= read & ~readPending_reg;
            readAddr_reg    <= address;
            if (write) begin
                if (address == `ADCC_OFF_CONV_CTRL) begin
                    startBit_reg      <= writedata[`ADCC_BIT_START];
                    channelSelect_reg <= writedata[2:0];
                end else if (address == `ADCC_OFF_CLK_PWR) begin
                    testBit_reg           <= writedata[`ADCC_BIT_TEST];
                    converterPowerOff_reg <= writedata[`ADCC_BIT_PWR_OFF];
                    clockSelect_reg       <= writedata[2:0];
                end else if (address == `ADCC_OFF_PIN_CFG) begin
                    pinEnables_reg <= writedata[4:0];
                end else if (address == `ADCC_OFF_IRQ_MASK) begin
                    irqMask_reg <= writedata[`ADCC_IRQ_DONE];
                end
            end
        end
    end

    // ****************************************************************
    // Read data
    // ****************************************************************
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            readdata <= 32'h00000000;
        end else if (clockEn) begin
            if (read & ~readPending_reg) begin
                if (address == `ADCC_OFF_RES_LOW) begin
                    readdata <= {24'h000000, resultWord[3:0], 4'h0};
                end else if (address == `ADCC_OFF_RES_HIGH) begin
                    readdata <= {24'h000000, resultWord[11:4]};
                end else if (address == `ADCC_OFF_CONV_CTRL) begin
                    readdata <= {24'h000000, startBit_reg, busy_reg,
                                 3'h0, channelSelect_reg};
                end else if (address == `ADCC_OFF_CLK_PWR) begin
                    readdata <= {24'h000000, testBit_reg, converterPowerOff_reg,
                                 3'h0, clockSelect_reg};
                end else if (address == `ADCC_OFF_PIN_CFG) begin
                    readdata <= {27'h0000000, pinEnables_reg};
                end else if (address == `ADCC_OFF_IRQ_STATUS) begin
                    readdata <= {31'h00000000, irqStatus_reg};
                end else if (address == `ADCC_OFF_IRQ_MASK) begin
                    readdata <= {31'h00000000, irqMask_reg};
                end else begin
                    readdata <= 32'h00000000;
                end
            end
        end
    end

    // ****************************************************************
    // Converter power, routing and clock
    // ****************************************************************
    assign converterOn      = (|pinEnables_reg) & ~converterPowerOff_reg;
    assign analogPinEnables = pinEnables_reg;
    assign analogInputSel   = inputSel;
    assign converterReset   = startBit_reg | ~converterOn;
    assign converterStart   = startFall & converterOn;

    always @* begin
        case (channelSelect_reg)
            3'h0:    inputSel = 3'h0;
            3'h1:    inputSel = 3'h1;
            3'h2:    inputSel = 3'h2;
            3'h3:    inputSel = 3'h3;
            3'h7:    inputSel = 3'h3;
            default: inputSel = 3'h4;
        endcase
    end

    always @* begin
        case (clockSelect_reg)
            `ADCC_CLK_DIV1:  divLimit = 5'h00;
            `ADCC_CLK_DIV2:  divLimit = 5'h01;
            `ADCC_CLK_DIV4:  divLimit = 5'h03;
            `ADCC_CLK_DIV8:  divLimit = 5'h07;
            `ADCC_CLK_DIV16: divLimit = 5'h0f;
            `ADCC_CLK_DIV32: divLimit = 5'h1f;
            default:         divLimit = 5'h01;
        endcase
        divCount_next = (divCount_reg >= divLimit) ? 5'h00 : divCount_reg + 5'h01;
    end

    assign converterClockEn = converterOn && (divCount_reg == 5'h00);

    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            divCount_reg <= 5'h00;
        end else if (clockEn) begin
            divCount_reg <= converterOn ? divCount_next : 5'h00;
        end
    end

    // ****************************************************************
    // Busy flag, end of conversion and interrupt
    // ****************************************************************
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            doneMeta_reg <= 1'b0;
            doneSync_reg <= 1'b0;
            doneSeen_reg <= 1'b0;
        end else if (clockEn) begin
            doneMeta_reg <= converterDone;
            doneSync_reg <= doneMeta_reg;
            doneSeen_reg <= doneSync_reg;
        end
    end

    assign doneRise      = doneSync_reg & ~doneSeen_reg;
    assign conversionEnd = busy_reg & ~startBit_reg & doneRise & converterOn;

    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            busy_reg      <= 1'b1;
            irqStatus_reg <= 1'b0;
        end else if (clockEn) begin
            if (startBit_reg) begin
                busy_reg <= 1'b1;
            end else if (conversionEnd) begin
                busy_reg <= 1'b0;
            end
            if (conversionEnd) begin
                irqStatus_reg <= 1'b1;
            end else if (readStatus) begin
                irqStatus_reg <= 1'b0;
            end
        end
    end

    assign irq = irqStatus_reg & irqMask_reg;

    adcc_result_store resultStore (
        .clock     (clock),
        .rstn      (rstn),
        .clockEn   (clockEn),
        .writeEn   (conversionEnd),
        .writeData (converterResult),
        .readData  (resultWord)
    );
endmodule // adcc_converter_control

/* File: logic/adcc_defines.vh */
// Register offsets, field positions, reset values and timing counts of the converter control
`ifndef ADCC_DEFINES_VH
`define ADCC_DEFINES_VH

`define ADCC_ADDR_W          4
`define ADCC_OFF_RES_LOW     4'h0
`define ADCC_OFF_RES_HIGH    4'h1
`define ADCC_OFF_CONV_CTRL   4'h2
`define ADCC_OFF_CLK_PWR     4'h3
`define ADCC_OFF_PIN_CFG     4'h4
`define ADCC_OFF_IRQ_STATUS  4'h5
`define ADCC_OFF_IRQ_MASK    4'h6

`define ADCC_BIT_START       7
`define ADCC_BIT_BUSY        6
`define ADCC_BIT_TEST        7
`define ADCC_BIT_PWR_OFF     6

`define ADCC_RST_CLK_PWR     8'hc0
`define ADCC_RST_PIN_CFG     5'h00
`define ADCC_RST_CHSEL       3'h0
`define ADCC_RST_CLKSEL      3'h0

`define ADCC_CLK_DIV2        3'h0
`define ADCC_CLK_DIV8        3'h1
`define ADCC_CLK_DIV32       3'h2
`define ADCC_CLK_DIV1        3'h4
`define ADCC_CLK_DIV4        3'h5
`define ADCC_CLK_DIV16       3'h6

`define ADCC_CONV_TICKS      5'h10
`define ADCC_IRQ_DONE        0

`endif

/* File: logic/adcc_result_store.v */
// Result holding registers for the 12-bit conversion value
`timescale 1ns/1ns
module adcc_result_store (
    input  wire        clock,
    input  wire        rstn,
    input  wire        clockEn,
    input  wire        writeEn,
    input  wire [11:0] writeData,
    output reg  [11:0] readData
);
    reg [11:0] store;

    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            store    <= 12'h000;
            readData <= 12'h000;
        end else if (clockEn) begin
            if (writeEn) begin
                store <= writeData;
            end
            readData <= writeEn ? writeData : store;
        end
    end
endmodule // adcc_result_store

/* File: test/adcc_core_model.sv */
// Behavioural model of the analog converter core
`timescale 1ns/1ns
module adcc_core_model #(parameter TICKS = 16) (
    input  wire        clock,
    input  wire        rstn,
    input  wire        converterReset,
    input  wire        converterStart,
    input  wire        converterClockEn,
    input  wire [2:0]  analogInputSel,
    output reg         converterDone,
    output reg  [11:0] converterResult
);
    localparam [4:0] LAST = TICKS - 1;
    reg       busyReg;
    reg [4:0] tickReg;
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            busyReg <= 1'b0;
            tickReg <= 5'h00;
            converterDone <= 1'b0;
            converterResult <= 12'h000;
        end else if (converterStart) begin
            // Start pulse comes while reset still stands, so it wins
            busyReg <= 1'b1;
            tickReg <= 5'h00;
            converterDone <= 1'b0;
        end else if (converterReset) begin
            busyReg <= 1'b0;
            converterDone <= 1'b0;
            converterResult <= ~converterResult;
        end else if (busyReg && converterClockEn) begin
            tickReg <= tickReg + 5'h01;
            if (tickReg == LAST) begin
                busyReg <= 1'b0;
                converterDone <= 1'b1;
                converterResult <= {1'b1, analogInputSel, 8'h3c};
            end
        end
    end
endmodule // adcc_core_model

/* File: test/adcc_props.sv */
// Port assertions for the converter control block
`timescale 1ns/1ns
module adcc_props (
    input wire        clock,
    input wire        rstn,
    input wire        clockEn,
    input wire        read,
    input wire        write,
    input wire [31:0] readdata,
    input wire        waitrequest,
    input wire        irq,
    input wire [4:0]  analogPinEnables,
    input wire [2:0]  analogInputSel,
    input wire        converterOn,
    input wire        converterReset,
    input wire        converterStart,
    input wire        converterClockEn
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    sequence readWait; read && waitrequest && clockEn; endsequence
    sequence readDone; !read || !waitrequest; endsequence
    a_read_one_wait: assert property (readWait |=> readDone)
        else $error("read waited more than one cycle");
    a_write_no_wait: assert property (write |-> !waitrequest)
        else $error("write was stalled");
    a_upper_zero: assert property (read && !waitrequest |-> readdata[31:8] == 24'h0)
        else $error("upper read data not zero");
    a_sel_range: assert property (analogInputSel <= 3'h4)
        else $error("routed input out of range");
    a_on_needs_pins: assert property (converterOn |-> analogPinEnables != 5'h00)
        else $error("converter on with no analog pin");
    a_off_held: assert property (!converterOn |-> converterReset && !converterClockEn)
        else $error("converter off but running");
    a_start_pulse: assert property (converterStart |=> !converterStart && !converterReset)
        else $error("start not a single pulse");
    a_irq_clear: assert property ($fell(irq) |-> $past(read) || $past(write))
        else $error("interrupt dropped without access");
endmodule // adcc_props

bind adcc_converter_control adcc_props u_props (.clock(clock), .rstn(rstn),
    .clockEn(clockEn), .read(read), .write(write), .readdata(readdata),
    .waitrequest(waitrequest), .irq(irq), .analogPinEnables(analogPinEnables),
    .analogInputSel(analogInputSel), .converterOn(converterOn),
    .converterReset(converterReset), .converterStart(converterStart),
    .converterClockEn(converterClockEn));

/* File: test/tb_adcc_converter_control.sv */
// Self-checking bench for the converter control block
`timescale 1ns/1ns
`include "adcc_defines.vh"
module tb_adcc_converter_control;
    reg         clock = 1'b0;
    reg         rstn = 1'b0;
    reg  [3:0]  address = 4'h0;
    reg         read = 1'b0;
    reg         write = 1'b0;
    reg  [31:0] writedata = 32'h0;
    reg  [31:0] rdata;
    wire [31:0] readdata;
    wire        waitrequest, irq, converterOn, converterReset;
    wire        converterStart, converterClockEn, converterDone;
    wire [4:0]  analogPinEnables;
    wire [2:0]  analogInputSel;
    wire [11:0] converterResult;
    integer     error_cnt = 0;
    integer     samples_checked = 0;
    integer     i, n;
    initial forever #5 clock = ~clock;
    adcc_converter_control DUT (.clock(clock), .rstn(rstn), .clockEn(1'b1),
        .address(address), .read(read), .write(write), .writedata(writedata),
        .readdata(readdata), .waitrequest(waitrequest), .irq(irq),
        .analogPinEnables(analogPinEnables), .analogInputSel(analogInputSel),
        .converterOn(converterOn), .converterReset(converterReset),
        .converterStart(converterStart), .converterClockEn(converterClockEn),
        .converterDone(converterDone), .converterResult(converterResult));
    adcc_core_model #(.TICKS(16)) model (.clock(clock), .rstn(rstn),
        .converterReset(converterReset), .converterStart(converterStart),
        .converterClockEn(converterClockEn), .analogInputSel(analogInputSel),
        .converterDone(converterDone), .converterResult(converterResult));
    task check(input [31:0] seen, input [31:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (seen !== exp) begin
                error_cnt = error_cnt + 1;
                $display("Error at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task stop_test;
        begin
            $display("Checks %0d, mismatches %0d", samples_checked, error_cnt);
            if (error_cnt == 0 && samples_checked > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    task acc(input rw, input [3:0] a, input [7:0] d);
        begin
            @(posedge clock);
            address <= a;
            writedata <= {24'h0, d};
            read <= !rw;
            write <= rw;
            n = 0;
            // Look at the answer mid-cycle, where it has settled
            @(negedge clock);
            while (waitrequest !== 1'b0 && n < 20) begin
                n = n + 1;
                @(negedge clock);
            end
            if (n == 20) error_cnt = error_cnt + 1;
            if (n == 20) stop_test;
            rdata = readdata;
            @(posedge clock);
            read <= 1'b0;
            write <= 1'b0;
            #1;
        end
    endtask
    task rd(input [3:0] a, input [31:0] e);
        begin
            acc(1'b0, a, 8'h00);
            check(rdata, e);
        end
    endtask
    function [2:0] selOf(input [2:0] c);
        selOf = (c == 3'h7) ? 3'h3 : (c > 3'h3) ? 3'h4 : c;
    endfunction
    function [31:0] divOf(input [2:0] s);
        case (s)
            3'h1: divOf = 8;
            3'h2: divOf = 32;
            3'h4: divOf = 1;
            3'h5: divOf = 4;
            3'h6: divOf = 16;
            default: divOf = 2;
        endcase
    endfunction
    task conv(input [2:0] c);
        begin
            acc(1'b1, `ADCC_OFF_CONV_CTRL, 8'h80 | c);
            check(converterReset, 1'b1);
            rd(`ADCC_OFF_CONV_CTRL, 32'hc0 | c);
            acc(1'b1, `ADCC_OFF_CONV_CTRL, {5'h00, c});
            i = 0;
            rdata = 32'h40;
            while (rdata[6] !== 1'b0 && i < 100) begin
                acc(1'b0, `ADCC_OFF_CONV_CTRL, 8'h00);
                i = i + 1;
            end
            check(rdata, {29'h0, c});
            rd(`ADCC_OFF_RES_LOW, 32'hc0);
            rd(`ADCC_OFF_RES_HIGH, {24'h0, 1'b1, selOf(c), 4'h3});
        end
    endtask
    initial begin
        repeat (16) @(posedge clock);
        rstn <= 1'b1;
        rd(`ADCC_OFF_CLK_PWR, 32'hc0);
        rd(`ADCC_OFF_CONV_CTRL, 32'h40);
        rd(`ADCC_OFF_PIN_CFG, 32'h0);
        rd(4'hf, 32'h0);
        check(converterReset, 1'b1);
        $display("Reset test done");
        for (i = 0; i < 8; i = i + 1) begin
            acc(1'b1, `ADCC_OFF_CONV_CTRL, 8'h38 | i);
            check(analogInputSel, selOf(i));
            rd(`ADCC_OFF_CONV_CTRL, 32'h40 | i);
        end
        acc(1'b1, `ADCC_OFF_PIN_CFG, 8'hff);
        rd(`ADCC_OFF_PIN_CFG, 32'h1f);
        check(analogPinEnables, 5'h1f);
        check(converterOn, 1'b0);
        $display("Channel and pin test done");
        for (i = 0; i < 7; i = i + 1) if (i != 3) begin
            acc(1'b1, `ADCC_OFF_CLK_PWR, 8'hb8 | i);
            rd(`ADCC_OFF_CLK_PWR, 32'h80 | i);
            check(converterOn, 1'b1);
            n = 0;
            while (converterClockEn !== 1'b1 && n < 64) begin
                @(posedge clock);
                n = n + 1;
            end
            n = 0;
            do begin
                @(posedge clock);
                n = n + 1;
            end while (converterClockEn !== 1'b1 && n < 64);
            check(n, divOf(i));
        end
        $display("Clock select test done");
        acc(1'b1, `ADCC_OFF_IRQ_MASK, 8'h01);
        conv(3'h2);
        check(irq, 1'b1);
        rd(`ADCC_OFF_IRQ_STATUS, 32'h1);
        check(irq, 1'b0);
        rd(`ADCC_OFF_IRQ_STATUS, 32'h0);
        acc(1'b1, `ADCC_OFF_IRQ_MASK, 8'h00);
        conv(3'h7);
        check(irq, 1'b0);
        rd(`ADCC_OFF_IRQ_STATUS, 32'h1);
        acc(1'b1, `ADCC_OFF_CONV_CTRL, 8'h80);
        rd(`ADCC_OFF_RES_HIGH, 32'hb3);
        $display("Conversion test done");
        acc(1'b1, `ADCC_OFF_PIN_CFG, 8'h00);
        check({converterOn, converterReset}, 2'b01);
        acc(1'b1, `ADCC_OFF_PIN_CFG, 8'h01);
        acc(1'b1, `ADCC_OFF_CLK_PWR, 8'hc4);
        check(converterOn, 1'b0);
        $display("Power test done");
        stop_test;
    end
endmodule // tb_adcc_converter_control
